// ==== design/rdw_pkg.sv ====
// Purpose: Constants and types for the receive status writeback engine
// Assumes: One clock (clk, 125 MHz), asynchronous active-low reset
// Notes:   Status word layout, frame size limits and engine states
//
// Contract
// - Bits 29:16 carry byte count including CRC
// - Length written only when last and untruncated
// - Bit 15 ORs bits 1,6,7,11,14
// - Overflow without next descriptor sets 14, truncates
// - Truncation flag only with last marker
// - Reserved bit 13 written as zero
// - Bit 12 flags length/type field mismatch
// - Bit 11 flags frame under 64 bytes
// - Runt frames kept only with pass-bad set
// - Bit 10 follows multicast destination
// - Bit 9 set only in first descriptor
// - Empty buffers skipped to find frame start
// - Bit 8 set only in final descriptor
// - Ownership cleared on close; unowned fetch suspends
// - Bit 7 flags oversize frame, no truncation
// - Bit 1 flags CRC or receive error
package rdw_pkg;

  localparam int                BUF_SIZE_W      = 11;
  localparam int                DESC_CNT_W      = 12;
  localparam int                FRAME_CNT_W     = 14;
  localparam int                WORD_W          = 32;

  // Status word field positions
  localparam int                OWN_BIT         = 31;
  localparam int                LEN_HI          = 29;
  localparam int                LEN_LO          = 16;
  localparam int                SUMMARY_BIT     = 15;
  localparam int                TRUNC_BIT       = 14;
  localparam int                RESERVED_BIT    = 13;
  localparam int                LEN_ERR_BIT     = 12;
  localparam int                SHORT_BIT       = 11;
  localparam int                GROUP_BIT       = 10;
  localparam int                FIRST_BIT       = 9;
  localparam int                LAST_BIT        = 8;
  localparam int                OVERSIZE_BIT    = 7;
  localparam int                LATE_COLL_BIT   = 6;
  localparam int                CRC_BIT         = 1;

  // Frame size limits in bytes
  localparam logic [FRAME_CNT_W-1:0] MIN_FRAME_BYTES = 14'h0040;
  localparam logic [FRAME_CNT_W-1:0] MAX_FRAME_BYTES = 14'h05EE;
  localparam logic [FRAME_CNT_W-1:0] MAX_VLAN_BYTES  = 14'h05F2;

  localparam logic [DESC_CNT_W-1:0]  DESC_ZERO       = 12'h000;
  localparam logic [DESC_CNT_W-1:0]  DESC_ONE        = 12'h001;
  localparam logic [FRAME_CNT_W-1:0] FRAME_ZERO      = 14'h0000;
  localparam logic [FRAME_CNT_W-1:0] FRAME_ONE       = 14'h0001;
  localparam logic [WORD_W-1:0]      WORD_ZERO       = 32'h0000_0000;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_RECV  = 6'h02,
    ST_FULL  = 6'h04,
    ST_NEXT  = 6'h08,
    ST_DRAIN = 6'h10,
    ST_SUSP  = 6'h20
  } rdw_state_type;

endpackage : rdw_pkg

// ==== design/rdw_status_if.sv ====
// Purpose: Carries closing-descriptor status fields to the word composer
// Assumes: Combinational path, same clock domain
// Notes:   Source fills fields, composer returns the packed word
interface rdw_status_if;
  import rdw_pkg::*;
  logic                   lastBuf;
  logic                   firstBuf;
  logic                   truncErr;
  logic                   crcErr;
  logic                   lateColl;
  logic                   tooLong;
  logic                   shortFrame;
  logic                   lenMismatch;
  logic                   groupAddr;
  logic [FRAME_CNT_W-1:0] byteCount;
  logic [WORD_W-1:0]      word;

  modport source   (output lastBuf, firstBuf, truncErr, crcErr, lateColl, tooLong,
                    shortFrame, lenMismatch, groupAddr, byteCount, input word);
  modport composer (input lastBuf, firstBuf, truncErr, crcErr, lateColl, tooLong,
                    shortFrame, lenMismatch, groupAddr, byteCount, output word);
endinterface : rdw_status_if

// ==== design/rdw_status_compose.sv ====
// Purpose: Packs closing-descriptor status into the writeback word
// Assumes: Fields are valid in the cycle the word is registered
// Notes:   Purely combinational; ownership bit always returned to host
module rdw_status_compose
  import rdw_pkg::*;
(
  rdw_status_if.composer sf
);

  logic truncLast;
  logic summary;

  // Truncation only legal in a closing descriptor
  assign truncLast = sf.truncErr & sf.lastBuf;
  assign summary   = sf.crcErr | sf.lateColl | sf.tooLong | sf.shortFrame | truncLast;

  always_comb begin
    sf.word                = WORD_ZERO;
    sf.word[OWN_BIT]       = 1'b0;
    if (sf.lastBuf && !truncLast) begin
      sf.word[LEN_HI:LEN_LO] = sf.byteCount;
    end
    sf.word[SUMMARY_BIT]   = summary;
    sf.word[TRUNC_BIT]     = truncLast;
    sf.word[RESERVED_BIT]  = 1'b0;
    sf.word[LEN_ERR_BIT]   = sf.lenMismatch;
    sf.word[SHORT_BIT]     = sf.shortFrame;
    sf.word[GROUP_BIT]     = sf.groupAddr;
    sf.word[FIRST_BIT]     = sf.firstBuf;
    sf.word[LAST_BIT]      = sf.lastBuf;
    sf.word[OVERSIZE_BIT]  = sf.tooLong;
    sf.word[LATE_COLL_BIT] = sf.lateColl;
    sf.word[CRC_BIT]       = sf.crcErr;
  end

endmodule : rdw_status_compose

// ==== design/rdw_writeback.sv ====
// Purpose: Receive descriptor tracking and status writeback
// Assumes: MAC path and fetch logic run on clk; no synchronisers needed
// Notes:   frameEnd arrives in a cycle without byteValid; both honoured only with rxReady
// Notes:   Zero-size descriptors go straight back when idle; a dropped runt reuses its descriptor
module rdw_writeback
  import rdw_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  descValid,
  input  wire logic                  descOwn,
  input  wire logic [BUF_SIZE_W-1:0] buf1Size,
  input  wire logic [BUF_SIZE_W-1:0] buf2Size,
  input  wire logic                  resume,
  input  wire logic                  byteValid,
  input  wire logic                  rxError,
  input  wire logic                  frameEnd,
  input  wire logic                  crcError,
  input  wire logic                  lateCollision,
  input  wire logic                  lengthMismatch,
  input  wire logic                  groupAddress,
  input  wire logic                  vlanEnable,
  input  wire logic                  passBadFrames,
  output logic                       descReq,
  output logic                       rxReady,
  output logic                       wbValid,
  output logic [WORD_W-1:0]          wbWord,
  output logic                       suspended
);

  rdw_state_type          state, next_state;
  logic [DESC_CNT_W-1:0]  capacity, next_capacity;
  logic [DESC_CNT_W-1:0]  descCount, next_descCount;
  logic [FRAME_CNT_W-1:0] frameCount, next_frameCount;
  logic                   firstHere, next_firstHere;
  logic                   errSeen, next_errSeen;
  logic                   next_wbValid;
  logic                   next_descReq;
  logic                   next_rxReady;
  logic                   next_suspended;
  logic [WORD_W-1:0]      next_wbWord;
  logic [DESC_CNT_W-1:0]  newCapacity;
  logic                   endShort;
  logic                   endLong;
  logic                   endCrc;

  // Status fields to the word composer
  rdw_status_if sf ();

  rdw_status_compose u_compose (
    .sf (sf.composer)
  );

  // Capacity of an offered descriptor; zero-size buffers contribute nothing
  assign newCapacity = {1'b0, buf1Size} + {1'b0, buf2Size};
  assign endShort    = frameCount < MIN_FRAME_BYTES;
  assign endLong     = frameCount > (vlanEnable ? MAX_VLAN_BYTES : MAX_FRAME_BYTES);
  assign endCrc      = crcError | errSeen | rxError;

  // Next-state, counters and closing status
  always_comb begin
    // Defaults: hold everything, no write
    next_state      = state;
    next_capacity   = capacity;
    next_descCount  = descCount;
    next_frameCount = frameCount;
    next_firstHere  = firstHere;
    next_errSeen    = errSeen;
    next_wbValid    = 1'b0;
    // Status flags are set only in a closing cycle; firstBuf (except on a zero-size handback) and byteCount follow the registers
    sf.lastBuf      = 1'b0;
    sf.firstBuf     = firstHere;
    sf.truncErr     = 1'b0;
    sf.crcErr       = 1'b0;
    sf.lateColl     = 1'b0;
    sf.tooLong      = 1'b0;
    sf.shortFrame   = 1'b0;
    sf.lenMismatch  = 1'b0;
    sf.groupAddr    = 1'b0;
    sf.byteCount    = frameCount;
    unique case (state)
      ST_IDLE: begin
        if (descValid) begin
          if (!descOwn) begin
            next_state = ST_SUSP;
          end else if (newCapacity == DESC_ZERO) begin
            // Nothing can start here: hand it back and fetch another
            sf.firstBuf  = 1'b0;
            next_wbValid = 1'b1;
          end else begin
            next_capacity   = newCapacity;
            next_descCount  = DESC_ZERO;
            next_frameCount = FRAME_ZERO;
            next_firstHere  = 1'b1;
            next_errSeen    = 1'b0;
            next_state      = ST_RECV;
          end
        end
      end
      ST_RECV, ST_FULL: begin
        if (rxError) begin
          next_errSeen = 1'b1;
        end
        if (frameEnd) begin
          if (endShort && !passBadFrames) begin
            // Dropped runt: rewind and reuse this descriptor
            next_descCount  = DESC_ZERO;
            next_frameCount = FRAME_ZERO;
            next_firstHere  = 1'b1;
            next_errSeen    = 1'b0;
            next_state      = ST_RECV;
          end else begin
            sf.lastBuf      = 1'b1;
            sf.crcErr       = endCrc;
            sf.lateColl     = lateCollision;
            sf.tooLong      = endLong;
            sf.shortFrame   = endShort;
            sf.lenMismatch  = lengthMismatch;
            sf.groupAddr    = groupAddress;
            next_wbValid    = 1'b1;
            next_state      = ST_IDLE;
          end
        end else if (byteValid) begin
          next_frameCount = frameCount + FRAME_ONE;
          if (state == ST_FULL) begin
            // Overflow byte held until the next descriptor is known
            next_state = ST_NEXT;
          end else begin
            next_descCount = descCount + DESC_ONE;
            if (descCount + DESC_ONE == capacity) begin
              next_state = ST_FULL;
            end
          end
        end
      end
      ST_NEXT: begin
        // Bytes are not taken while the fetch is out; only receive errors are recorded
        if (rxError) begin
          next_errSeen = 1'b1;
        end
        if (descValid) begin
          if (descOwn && newCapacity != DESC_ZERO) begin
            next_wbValid   = 1'b1;
            next_capacity  = newCapacity;
            next_descCount = DESC_ONE;
            next_firstHere = 1'b0;
            next_state     = (newCapacity == DESC_ONE) ? ST_FULL : ST_RECV;
          end else begin
            // No room left: close as truncated last descriptor
            sf.lastBuf   = 1'b1;
            sf.truncErr  = 1'b1;
            sf.crcErr    = endCrc;
            sf.groupAddr = groupAddress;
            next_wbValid = 1'b1;
            next_state   = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        // Remaining bytes discarded until the frame ends
        if (frameEnd) begin
          next_state = ST_SUSP;
        end
      end
      ST_SUSP: begin
        // Only a resume from outside restarts fetching
        if (resume) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // State group registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      capacity   <= DESC_ZERO;
      descCount  <= DESC_ZERO;
      frameCount <= FRAME_ZERO;
      firstHere  <= 1'b0;
      errSeen    <= 1'b0;
    end else begin
      state      <= next_state;
      capacity   <= next_capacity;
      descCount  <= next_descCount;
      frameCount <= next_frameCount;
      firstHere  <= next_firstHere;
      errSeen    <= next_errSeen;
    end
  end

  // Output next values; strobes decoded from the next state, word loaded on a write, so every output is a plain flop
  always_comb begin
    next_wbWord    = wbWord;
    if (next_wbValid) begin
      // Word taken whole so ownership and status reach the host together
      next_wbWord = sf.word;
    end
    next_descReq   = (next_state == ST_IDLE) || (next_state == ST_NEXT);
    next_rxReady   = (next_state == ST_RECV) || (next_state == ST_FULL) || (next_state == ST_DRAIN);
    next_suspended = (next_state == ST_SUSP);
  end

  // Output registers; the word holds between writes for the host to read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wbValid   <= 1'b0;
      wbWord    <= WORD_ZERO;
      descReq   <= 1'b0;
      rxReady   <= 1'b0;
      suspended <= 1'b0;
    end else begin
      wbValid   <= next_wbValid;
      wbWord    <= next_wbWord;
      descReq   <= next_descReq;
      rxReady   <= next_rxReady;
      suspended <= next_suspended;
    end
  end

endmodule : rdw_writeback

// ==== verif/rdw_monitor.sv ====
// Purpose: Port-level checks for the receive status writeback engine
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached to rdw_writeback by bind
module rdw_monitor
  import rdw_pkg::*;
(
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              frameEnd,
  input wire logic              passBadFrames,
  input wire logic              resume,
  input wire logic              rxReady,
  input wire logic              wbValid,
  input wire logic [WORD_W-1:0] wbWord,
  input wire logic              suspended
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // End accepted by the engine, and a status write going out
  sequence s_end_taken;
    frameEnd && rxReady;
  endsequence
  sequence s_write;
    wbValid;
  endsequence
  // A close may follow a continuation write at once; after a truncated write the engine only drains
  a_write_pulse: assert property (s_write ##0 wbWord[TRUNC_BIT] |=> !wbValid)
    else $error("write strobe too long");
  a_own_returned: assert property (s_write |-> !wbWord[OWN_BIT])
    else $error("ownership kept");
  a_reserved_zero: assert property (s_write |-> !wbWord[RESERVED_BIT])
    else $error("reserved bit set");
  a_summary_or: assert property (s_write |-> wbWord[SUMMARY_BIT] == (wbWord[CRC_BIT] |
    wbWord[LATE_COLL_BIT] | wbWord[OVERSIZE_BIT] | wbWord[SHORT_BIT] | wbWord[TRUNC_BIT]))
    else $error("summary wrong");
  a_trunc_last: assert property (s_write ##0 wbWord[TRUNC_BIT] |-> wbWord[LAST_BIT])
    else $error("truncation without last");
  a_len_gated: assert property (s_write ##0 !(wbWord[LAST_BIT] && !wbWord[TRUNC_BIT])
    |-> wbWord[LEN_HI:LEN_LO] == FRAME_ZERO)
    else $error("length in wrong word");
  // Truncated drain closes without a write, so it is left out here
  a_end_writes: assert property (s_end_taken ##0 (passBadFrames && !wbWord[TRUNC_BIT]) |=> wbValid)
    else $error("no write after end");
  a_word_held: assert property (!wbValid |-> $stable(wbWord))
    else $error("word moved");
  a_susp_hold: assert property (suspended && !resume |=> suspended)
    else $error("left suspend alone");
  a_susp_quiet: assert property (suspended |-> !rxReady && !wbValid)
    else $error("busy while suspended");
endmodule : rdw_monitor
bind rdw_writeback rdw_monitor u_mon (.clk, .arst_n, .frameEnd, .passBadFrames, .resume, .rxReady, .wbValid,
  .wbWord, .suspended);

// ==== verif/rdw_host_model.sv ====
// Purpose: Host side, hands out descriptors and collects status words
// Assumes: Fetch answered LAG cycles after a request is seen
// Notes:   Sizes read back inverted outside an offer
module rdw_host_model
  import rdw_pkg::*;
#(parameter int LAG = 3)
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  descReq,
  input  wire logic                  offerEn,
  input  wire logic                  own,
  input  wire logic [BUF_SIZE_W-1:0] s1,
  input  wire logic [BUF_SIZE_W-1:0] s2,
  input  wire logic                  wbValid,
  input  wire logic [WORD_W-1:0]     wbWord,
  output logic                       descValid,
  output logic                       descOwn,
  output logic [BUF_SIZE_W-1:0]      buf1Size,
  output logic [BUF_SIZE_W-1:0]      buf2Size
);
  logic [WORD_W-1:0]      words[$];
  logic [FRAME_CNT_W-1:0] frameLen;
  int                     lagCnt;
  // Slow fetch gives the bench time to withdraw offers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lagCnt    <= 0;
      descValid <= 1'b0;
    end else begin
      lagCnt    <= (descReq && offerEn) ? lagCnt + 1 : 0;
      descValid <= descReq && offerEn && lagCnt == LAG;
    end
  end
  assign descOwn  = descValid ? own : !own;
  assign buf1Size = descValid ? s1 : ~s1;
  assign buf2Size = descValid ? s2 : ~s2;
  // Size taken from the closing word only; bit 13 never looked at
  always @(posedge clk) begin
    if (wbValid === 1'b1) begin
      if (wbWord[LAST_BIT]) frameLen = wbWord[LEN_HI:LEN_LO];
      words.push_back(wbWord);
    end
  end
endmodule : rdw_host_model

// ==== verif/rdw_tb.sv ====
// Purpose: Self-checking bench for the receive status writeback engine
// Assumes: 125 MHz clock, host answers descriptor requests after a lag
// Notes:   Words are judged as the host model collects them
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module testbench
  import rdw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0, arst_n = 1'b0, offerEn = 1'b0, own = 1'b1, resume = 1'b0;
  logic                  byteValid = 1'b0, frameEnd = 1'b0, rxError = 1'b0, crcError = 1'b0;
  logic                  lateCollision = 1'b0, lengthMismatch = 1'b0, groupAddress = 1'b0;
  logic                  vlanEnable = 1'b0, passBadFrames = 1'b0;
  logic [BUF_SIZE_W-1:0] s1 = 11'h000, s2 = 11'h000, buf1Size, buf2Size;
  logic                  descValid, descOwn, descReq, rxReady, wbValid, suspended;
  logic [WORD_W-1:0]     wbWord, w;
  int                    error_cnt = 0, total_checks = 0;
  always #4 clk = ~clk;
  rdw_writeback dut (.clk, .arst_n, .descValid, .descOwn, .buf1Size, .buf2Size, .resume, .byteValid, .rxError,
    .frameEnd, .crcError, .lateCollision, .lengthMismatch, .groupAddress, .vlanEnable, .passBadFrames,
    .descReq, .rxReady, .wbValid, .wbWord, .suspended);
  rdw_host_model #(.LAG(3)) host (.clk, .arst_n, .descReq, .offerEn, .own, .s1, .s2, .wbValid, .wbWord,
    .descValid, .descOwn, .buf1Size, .buf2Size);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Bounded waiting; running out counts as a mismatch
  task automatic stall(inout int k);
    k++;
    if (k > 600) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : stall
  task automatic take(input int n);
    int k = 0;
    while (n > 0) begin
      @(posedge clk);
      if (rxReady === 1'b1) n--;
      else stall(k);
    end
  endtask : take
  task automatic bytes(input int n);
    byteValid <= 1'b1;
    take(n);
    byteValid <= 1'b0;
  endtask : bytes
  // Status order: crc, late collision, length mismatch, group, receive error
  task automatic fin(input logic [4:0] st);
    {crcError, lateCollision, lengthMismatch, groupAddress, rxError} <= st;
    frameEnd <= 1'b1;
    take(1);
    frameEnd <= 1'b0;
    // Status left high would leak into the next frame as its error and address flags
    {crcError, lateCollision, lengthMismatch, groupAddress, rxError} <= 5'h00;
  endtask : fin
  task automatic got();
    int k = 0;
    while (host.words.size() == 0) begin
      @(posedge clk);
      stall(k);
    end
    w = host.words.pop_front();
  endtask : got
  task automatic susp();
    int k = 0;
    while (suspended !== 1'b1) begin
      @(posedge clk);
      stall(k);
    end
  endtask : susp
  task automatic cfg(input logic [BUF_SIZE_W-1:0] a, input logic [BUF_SIZE_W-1:0] b);
    @(posedge clk);
    s1      <= a;
    s2      <= b;
    offerEn <= 1'b1;
  endtask : cfg
  // Flags: first, last, trunc, crc, late coll, oversize, short, len err, group
  function automatic logic [WORD_W-1:0] ew(input logic [FRAME_CNT_W-1:0] len, input logic [8:0] f);
    logic [WORD_W-1:0] x;
    x = WORD_ZERO;
    x[LEN_HI:LEN_LO] = len;
    {x[FIRST_BIT], x[LAST_BIT], x[TRUNC_BIT], x[CRC_BIT], x[LATE_COLL_BIT]} = f[8:4];
    {x[OVERSIZE_BIT], x[SHORT_BIT], x[LEN_ERR_BIT], x[GROUP_BIT]} = f[3:0];
    x[SUMMARY_BIT] = x[CRC_BIT] | x[LATE_COLL_BIT] | x[OVERSIZE_BIT] | x[SHORT_BIT] | x[TRUNC_BIT];
    return x;
  endfunction : ew
  task automatic t_zero();
    cfg(11'h000, 11'h000);
    got();
    offerEn <= 1'b0;
    `CHK(w, WORD_ZERO)
    $display("empty descriptor test done");
  endtask : t_zero
  task automatic t_frames();
    cfg(11'h03C, 11'h004);
    bytes(64);
    fin(5'h03);
    got();
    offerEn <= 1'b0;
    `CHK(w, ew(14'h0040, 9'h1A1))
    `CHK(host.frameLen, 14'h0040)
    cfg(11'h000, 11'h028);
    bytes(70);
    fin(5'h02);
    got();
    `CHK(w, ew(FRAME_ZERO, 9'h100))
    got();
    offerEn <= 1'b0;
    `CHK(w, ew(14'h0046, 9'h081))
    $display("frame test done");
  endtask : t_frames
  task automatic t_runt();
    cfg(11'h040, 11'h000);
    bytes(10);
    fin(5'h00);
    repeat (20) @(posedge clk);
    `CHK(host.words.size(), 0)
    passBadFrames <= 1'b1;
    bytes(10);
    fin(5'h00);
    got();
    offerEn <= 1'b0;
    `CHK(w, ew(14'h000A, 9'h184))
    $display("runt test done");
  endtask : t_runt
  task automatic t_size();
    cfg(11'h7FF, 11'h000);
    bytes(1519);
    fin(5'h1C);
    got();
    offerEn    <= 1'b0;
    vlanEnable <= 1'b1;
    `CHK(w, ew(14'h05EF, 9'h1BA))
    cfg(11'h7FF, 11'h000);
    bytes(1522);
    fin(5'h00);
    got();
    offerEn <= 1'b0;
    `CHK(w, ew(14'h05F2, 9'h180))
    $display("size test done");
  endtask : t_size
  task automatic t_trunc();
    cfg(11'h028, 11'h000);
    bytes(40);
    own <= 1'b0;
    @(posedge clk);
    bytes(6);
    fin(5'h00);
    got();
    offerEn <= 1'b0;
    own     <= 1'b1;
    `CHK(w, ew(FRAME_ZERO, 9'h1C0))
    susp();
    `CHK(suspended, 1'b1)
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    @(posedge clk);
    `CHK(suspended, 1'b0)
    `CHK(descReq, 1'b1)
    // Unowned descriptor fetched while idle: suspend with no write
    own <= 1'b0;
    cfg(11'h040, 11'h000);
    susp();
    offerEn <= 1'b0;
    own     <= 1'b1;
    `CHK(host.words.size(), 0)
    `CHK(rxReady, 1'b0)
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    $display("truncation test done");
  endtask : t_trunc
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_zero();
    t_frames();
    t_runt();
    t_size();
    t_trunc();
    tally_and_finish();
  end
endmodule : testbench
